// *** design/wdrt_pkg.sv ***
/*
  constants, field layout and carrier types shared by the watchdog
  reset timer and its two helper modules.
  assumes a single 200 MHz clock domain and a 16-bit register port.
*/
// ============================================================
// package
package wdrt_pkg;

  // ============================================================
  // clock and time base
  localparam int unsigned REF_CLK_HZ = 200_000_000;
  localparam int unsigned SRC_CLK_HZ = 5_000_000;
  // tick rate of 39062.5 Hz, kept doubled to stay integral
  localparam int unsigned TICK_HZ_X2 = 78_125;
  localparam int unsigned SRC_DIV = REF_CLK_HZ / SRC_CLK_HZ;
  localparam int unsigned TICK_DIV = (2 * SRC_CLK_HZ) / TICK_HZ_X2;
  localparam int unsigned TICK_CYCLES = SRC_DIV * TICK_DIV;
  // shortest and longest overflow periods, in microseconds
  localparam int unsigned MIN_TIMEOUT_US = 6_550;
  localparam int unsigned MAX_TIMEOUT_US = 419_430;
  // length of the reset pulse driven out
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RST_PULSE_NS = 40;
  localparam int unsigned RST_PULSE_CYCLES =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ============================================================
  // widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PS_W = 3;
  localparam int unsigned PRE_W = 6;
  localparam int unsigned TICK_W = 16;
  localparam int unsigned HOLD_W = 4;

  // ============================================================
  // register map inside the frame at 7020h
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 16'h7023;
  localparam logic [ADDR_W-1:0] ADDR_KEY = 16'h7025;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 16'h7029;

  // ============================================================
  // control register fields
  localparam int unsigned PS_LSB = 0;
  localparam int unsigned CHK_LSB = 3;
  localparam logic [2:0] CHK_PATTERN = 3'h5;
  localparam logic [PS_W-1:0] PS_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 8'hFF;
  localparam logic [REG_W-1:0] SERVICE_KEY_DEFAULT = 8'h5A;

  // ============================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wdrt_bus_req_t;

  typedef struct packed {
    logic overflow;
    logic badKey;
    logic badCheck;
  } wdrt_cause_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FIRE = 2'b01,
    ST_HOLD = 2'b11
  } wdrt_state_t;

endpackage

// *** design/wdrt_prescaler.sv ***
/*
  power-of-two prescaler on the watchdog tick: passes one tick out of
  1, 2, 4 ... 64 according to a mask.
  assumes tick is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// prescaler
module wdrt_prescaler
  import wdrt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic tick,
  input wire logic [PRE_W-1:0] mask,
  // divided tick, combinational toward the counter
  output logic divTick
);

  logic [PRE_W-1:0] phase_reg;
  logic [PRE_W-1:0] phase_next;

  // a divided tick is due when all masked phase bits are ones
  assign divTick = tick && ((phase_reg & mask) == mask) && !clear;
  assign phase_next = clear ? '0 : (tick ? phase_reg + 1'b1 : phase_reg);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

endmodule
`default_nettype wire

// *** design/wdrt_tick_gen.sv ***
/*
  free-running divider that turns the 200 MHz clock into one-cycle
  pulses at the watchdog tick rate.
  assumes the parent supplies the period in clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// tick generator
module wdrt_tick_gen
  import wdrt_pkg::*;
#(
  parameter int unsigned TickCycles = TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // tick out
  output logic tick
);

  localparam logic [TICK_W-1:0] TickLast = TICK_W'(TickCycles - 1);

  logic [TICK_W-1:0] count_reg;
  logic [TICK_W-1:0] count_next;
  wire atEnd = (count_reg == TickLast);

  assign count_next = atEnd ? '0 : count_reg + 1'b1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= atEnd;
    end
  end

endmodule
`default_nettype wire

// *** design/wdrt_watchdog.sv ***
/*
  watchdog reset timer: 8-bit counter on a divided low-rate tick,
  service key register, checked control register, reset pulse out.
  assumes the register port runs on ref_clk and that sysReset is fed
  back into the chip reset, which in turn drives rst_n.
  the pulse out is only a request: the pulse itself clears just the
  counter, the prescaler phase and the prescale field, so resetCause survives it.
  writes that arrive while the pulse runs are dropped without a sign.
*/
// The strobed register port and the register addresses were left to the implementer.
// What this block does
// - overflow of the unserviced counter asserts a system reset
// - runs on its own tick, always enabled, needs no setup
// - any reset returns the prescaler to the shortest period
// - counting starts as soon as reset is released
// - correct key clears the counter; a wrong key resets
// - control writes need 101 in bits 5..3 or reset follows
// - prescale 00x,010..111 divides by 1,2,4,8,16,32,64
// - seven periods from about 6.55 ms to 419.43 ms
// - tick of 39.0625 kHz derived from a 5 MHz base
// - 8-bit registers in low byte; high byte reads zero
// - three registers in the frame starting at 7020h
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// top
module wdrt_watchdog
  import wdrt_pkg::*;
#(
  // cycles of ref_clk per watchdog tick; shorten for simulation
  parameter int unsigned TickCycles = TICK_CYCLES,
  parameter logic [REG_W-1:0] ServiceKey = SERVICE_KEY_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire wdrt_bus_req_t busReq,
  output logic [DATA_W-1:0] rdData,
  // reset request and its cause
  output logic sysReset,
  output wdrt_cause_t resetCause
);

  // ============================================================
  // functions

  // divider mask for the prescale field; 00x both divide by one
  function automatic logic [PRE_W-1:0] presc_mask(
    input logic [PS_W-1:0] ps
  );
    logic [PRE_W-1:0] m;
    m = '0;
    case (ps)
      3'h0: m = 6'h00;
      3'h1: m = 6'h00;
      3'h2: m = 6'h01;
      3'h3: m = 6'h03;
      3'h4: m = 6'h07;
      3'h5: m = 6'h0F;
      3'h6: m = 6'h1F;
      3'h7: m = 6'h3F;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  // zero-extend an 8-bit register into the 16-bit read word
  function automatic logic [DATA_W-1:0] low_byte(
    input logic [REG_W-1:0] v
  );
    return {{(DATA_W-REG_W){1'b0}}, v};
  endfunction

  // full address compare; a partial decode would alias the whole frame
  function automatic logic addr_match(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    return (a == target);
  endfunction

  // ============================================================
  // state

  wdrt_state_t state_reg;
  wdrt_state_t state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [PS_W-1:0] presc_reg;
  logic [PS_W-1:0] presc_next;
  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic sysReset_reg;
  logic sysReset_next;
  wdrt_cause_t cause_reg;
  wdrt_cause_t cause_next;

  localparam logic [HOLD_W-1:0] HoldLast =
    HOLD_W'(RST_PULSE_CYCLES - 1);

  // ============================================================
  // bus decode

  wire running = (state_reg == ST_RUN);
  wire [REG_W-1:0] wrByte = busReq.wdata[REG_W-1:0];
  wire hitCounter = addr_match(busReq.addr, ADDR_COUNTER);
  wire hitKey = addr_match(busReq.addr, ADDR_KEY);
  wire hitControl = addr_match(busReq.addr, ADDR_CONTROL);
  // the register block takes writes only while the timer runs; reads are answered in every state
  wire wrKey = busReq.wr && hitKey && running;
  wire wrControl = busReq.wr && hitControl && running;

  // the upper byte of a write never reaches any register
  wire keyGood = (wrByte == ServiceKey);
  wire [2:0] chkBits = wrByte[CHK_LSB+2:CHK_LSB];
  wire chkGood = (chkBits == CHK_PATTERN);

  // a good key clears, a wrong one fires
  wire serviceHit = wrKey && keyGood;
  wire keyFault = wrKey && !keyGood;
  // control writes must carry the check pattern
  wire checkFault = wrControl && !chkGood;
  wire controlLoad = wrControl && chkGood;

  // ============================================================
  // time base

  logic tick;
  logic divTick;
  wire [PRE_W-1:0] mask = presc_mask(presc_reg);
  // a service restarts the prescaler too, so a full period follows
  wire prescClear = serviceHit || !running;

  // 200 MHz down to the 39.0625 kHz tick via the 5 MHz base
  wdrt_tick_gen #(
    .TickCycles(TickCycles)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  wdrt_prescaler u_presc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(prescClear),
    .tick(tick),
    .mask(mask),
    .divTick(divTick)
  );

  // ============================================================
  // counter and overflow

  // 256 divided ticks from clear to overflow
  wire overflow = running && divTick &&
    (count_reg == CNT_LAST);

  // one pulse per incident: faults during fire or hold are not taken
  wire anyFault = overflow || keyFault || checkFault;

  always_comb begin
    count_next = count_reg;
    if (!running || serviceHit) begin
      count_next = CNT_RESET;
    end else if (divTick) begin
      // no enable exists: the counter always advances
      count_next = count_reg + 1'b1;
    end
  end

  always_comb begin
    presc_next = presc_reg;
    if (state_reg == ST_HOLD) begin
      // a watchdog reset also restores the shortest period
      presc_next = PS_RESET;
    end else if (controlLoad) begin
      presc_next = wrByte[PS_LSB+PS_W-1:PS_LSB];
    end
  end

  // ============================================================
  // reset sequencer

  // state walk: fire for one cycle, then hold the pulse
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (anyFault) begin
          state_next = ST_FIRE;
        end
      end
      ST_FIRE: begin
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (hold_reg == HoldLast) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // pulse length counter, restarted on entry to the hold state
  always_comb begin
    hold_next = hold_reg;
    case (state_reg)
      ST_FIRE: begin
        hold_next = '0;
      end
      ST_HOLD: begin
        if (hold_reg != HoldLast) begin
          hold_next = hold_reg + 1'b1;
        end
      end
      default: begin
        hold_next = hold_reg;
      end
    endcase
  end

  // the pulse rises on leaving fire and falls after the last hold cycle
  always_comb begin
    sysReset_next = 1'b0;
    case (state_reg)
      ST_FIRE: begin
        sysReset_next = 1'b1;
      end
      ST_HOLD: begin
        sysReset_next = (hold_reg != HoldLast);
      end
      default: begin
        sysReset_next = 1'b0;
      end
    endcase
  end

  // the reason stays until the next fault so a handler can tell why
  always_comb begin
    cause_next = cause_reg;
    if (anyFault) begin
      cause_next.overflow = overflow;
      cause_next.badKey = keyFault;
      cause_next.badCheck = checkFault;
    end
  end

  // ============================================================
  // read path

  // control reads back the prescale field; check bits read zero
  wire [REG_W-1:0] controlView = {{(REG_W-PS_W){1'b0}}, presc_reg};
  wire [DATA_W-1:0] counterWord = low_byte(count_reg);
  wire [DATA_W-1:0] controlWord = low_byte(controlView);
  // key reads zero, as do unmapped addresses
  wire [DATA_W-1:0] readMux =
    hitCounter ? counterWord :
    hitControl ? controlWord :
    '0;

  // data stands for exactly the cycle after the strobe
  assign rdData_next = busReq.rd ? readMux : '0;

  // ============================================================
  // registers

  // rst_n is the only asynchronous clear of every register
  // counting begins on the first edge after rst_n rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= PS_RESET;
    end else begin
      presc_reg <= presc_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysReset_reg <= 1'b0;
    end else begin
      sysReset_reg <= sysReset_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= cause_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ============================================================
  // outputs

  assign rdData = rdData_reg;
  assign sysReset = sysReset_reg;
  assign resetCause = cause_reg;

endmodule
`default_nettype wire

// *** test/testbench.sv ***
/*
  directed testbench for the watchdog reset timer.
  assumes a shortened tick period so every timeout fits the run.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
module testbench
  import wdrt_pkg::*;
;
  localparam int unsigned TC = 2;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wdrt_bus_req_t busReq = '0;
  logic [DATA_W-1:0] rdData;
  logic sysReset;
  wdrt_cause_t resetCause;
  logic [DATA_W-1:0] d;
  int fail_count = 0;
  int check_count = 0;
  int n;
  int dv;

  wdrt_watchdog #(.TickCycles(TC), .ServiceKey(8'h5A)) i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .busReq(busReq),
    .rdData(rdData),
    .sysReset(sysReset),
    .resetCause(resetCause)
  );
  // ============================================================
  // helpers
  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    busReq.addr <= a;
    busReq.wdata <= v;
    busReq.wr <= 1'b1;
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask
  // waits for the pulse, counting cycles in n, then times its length
  task automatic fire(input logic [2:0] c, input int lim);
    int k;
    n = 0;
    while (sysReset !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > lim) begin
        fail_count++;
        results();
      end
    end
    chk({13'h0, resetCause}, {13'h0, c});
    k = 0;
    while (sysReset === 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk(16'(k), 16'(RST_PULSE_CYCLES));
  endtask
  // ============================================================
  // scenarios
  task automatic t_start();
    rd(ADDR_CONTROL);
    chk(d, 16'h0000);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_COUNTER);
    chk(16'(d != 16'h0000), 16'h0001);
    $display("test start done");
  endtask
  task automatic t_regs();
    wr(ADDR_CONTROL, 16'hFF2E);
    rd(ADDR_CONTROL);
    chk(d, 16'h0006);
    rd(ADDR_KEY);
    chk(d, 16'h0000);
    rd(16'h7020);
    chk(d, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL);
    chk(d, 16'h0000);
    // let the counter climb well past two before the service
    repeat (40) @(posedge ref_clk);
    // upper byte of the key is not part of the match
    wr(ADDR_KEY, 16'hFF5A);
    rd(ADDR_COUNTER);
    chk(16'(d <= 16'h0002), 16'h0001);
    chk({13'h0, resetCause}, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_service();
    wr(ADDR_CONTROL, 16'h0028);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_KEY, 16'h005A);
      repeat (400) @(posedge ref_clk);
    end
    #1 chk({13'h0, resetCause}, 16'h0000);
    $display("test service done");
  endtask
  task automatic t_overflow();
    for (int ps = 0; ps < 8; ps++) begin
      dv = (ps < 2) ? 1 : (1 << (ps - 1));
      wr(ADDR_CONTROL, 16'(16'h0028 | ps));
      wr(ADDR_KEY, 16'h005A);
      fire(3'b100, 40000);
      chk(16'(n >= 256 * dv * TC - 8 &&
              n <= 256 * dv * TC + 8), 16'h0001);
    end
    rd(ADDR_CONTROL);
    chk(d, 16'h0000);
    $display("test overflow done");
  endtask
  task automatic t_badkey();
    wr(ADDR_KEY, 16'h00A5);
    fire(3'b010, 10);
    chk(16'(n), 16'h0001);
    $display("test bad key done");
  endtask
  task automatic t_badchk();
    for (int p = 0; p < 8; p++) begin
      if (p != 5) begin
        wr(ADDR_CONTROL, 16'((p << 3) | 7));
        fire(3'b001, 10);
        chk(16'(n), 16'h0001);
      end
    end
    rd(ADDR_CONTROL);
    chk(d, 16'h0000);
    $display("test bad check done");
  endtask
  // ============================================================
  // main
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_start();
    t_regs();
    t_service();
    t_overflow();
    t_badkey();
    t_badchk();
    results();
  end
endmodule
`default_nettype wire

// *** test/wdrt_watchdog_asserts.sv ***
/*
  concurrent checks on the watchdog reset timer ports.
  assumes one ref_clk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker
module wdrt_watchdog_asserts
  import wdrt_pkg::*;
#(
  parameter logic [REG_W-1:0] ServiceKey = SERVICE_KEY_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire wdrt_bus_req_t busReq,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic sysReset,
  input wire wdrt_cause_t resetCause
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic keyWr = busReq.wr && busReq.addr == ADDR_KEY;
  wire logic badKey = keyWr && busReq.wdata[7:0] != ServiceKey;
  wire logic badChk = busReq.wr && busReq.addr == ADDR_CONTROL &&
    busReq.wdata[5:3] != CHK_PATTERN;
  wire logic cntRd = busReq.rd && busReq.addr == ADDR_COUNTER;
  // ============================================================
  // properties
  rd_idle_a: assert property (!$past(busReq.rd) |-> rdData == '0)
    else $error("read data outside the answer cycle");
  high_byte_a: assert property (rdData[15:8] == 8'h00)
    else $error("upper read byte not zero");
  key_read_a: assert property (busReq.rd && busReq.addr == ADDR_KEY
    |=> rdData == '0) else $error("key register read not zero");
  bad_key_a: assert property (badKey && !sysReset |-> ##2 sysReset)
    else $error("wrong key gave no reset");
  key_cause_a: assert property ($rose(resetCause.badKey) |-> $past(badKey))
    else $error("key cause without wrong key");
  bad_check_a: assert property (badChk && !sysReset |-> ##2 sysReset)
    else $error("bad check bits gave no reset");
  chk_cause_a: assert property ($rose(resetCause.badCheck) |-> $past(badChk))
    else $error("check cause without bad write");
  pulse_len_a: assert property ($rose(sysReset) |->
    sysReset [*8] ##1 !sysReset) else $error("reset pulse length wrong");
  pulse_cause_a: assert property ($rose(sysReset) |-> resetCause != '0)
    else $error("reset pulse without cause");
  service_clr_a: assert property ((keyWr && !badKey && !sysReset) ##2 cntRd
    |=> rdData <= 16'h0002) else $error("good key did not clear counter");
endmodule
bind wdrt_watchdog wdrt_watchdog_asserts #(.ServiceKey(ServiceKey)) i_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .rdData(rdData),
  .sysReset(sysReset),
  .resetCause(resetCause)
);
`default_nettype wire
